//--- common/daoc_defs.vh
/*
 * Constants for the dual converter output control block: register
 * offsets and fields, reset values, calibration and recovery timing.
 * Assumes a 25 MHz pclk; cycle counts are derived from that period.
 */
`ifndef DAOC_DEFS_VH
`define DAOC_DEFS_VH

// Register byte offsets
`define DAOC_REG_CTRL 8'h00
`define DAOC_REG_STATUS 8'h04
`define DAOC_REG_OFFSET 8'h08

// Control register fields and reset value
`define DAOC_CTRL_CORR_EN_BIT 0
`define DAOC_CTRL_RESET 32'h00000001

// Status register field positions
`define DAOC_STAT_PARALLEL_BIT 0
`define DAOC_STAT_TWOS_BIT 1
`define DAOC_STAT_GAIN_BIT 2
`define DAOC_STAT_STATE_LSB 4
`define DAOC_STAT_CAL_BUSY_BIT 8

// Offset register field positions
`define DAOC_OFFS_I_LSB 0
`define DAOC_OFFS_Q_LSB 16

// Sample code constants
`define DAOC_MIDSCALE 11'h200
`define DAOC_CODE_MAX 10'h3FF

// Offset calibration timing
`define DAOC_CAL_CYCLES 34
`define DAOC_CAL_SAMPLES 3
`define DAOC_CAL_FIRST 1

// Clock period and recovery times
`define DAOC_CLK_PERIOD 40
`define DAOC_STANDBY_TIME 800
`define DAOC_SLEEP_TIME 1000000
`define DAOC_STANDBY_CYCLES (`DAOC_STANDBY_TIME / `DAOC_CLK_PERIOD)
`define DAOC_SLEEP_CYCLES ((`DAOC_SLEEP_TIME / `DAOC_CLK_PERIOD) - 1)
// Edges from pin release to first new word, taken off the wake count
`define DAOC_WAKE_PIPE 16'h0005

`endif

//--- verilog/daoc_top.v
/*
 * Output control of a dual 10-bit sampling converter: sample capture,
 * offset self-correction, output coding, parallel or multiplexed bus,
 * channel phase flag, standby and deep-sleep sequencing, APB status.
 * Assumes raw converter codes arrive in the pclk domain, valid at the
 * falling edge; control pins are asynchronous and are synchronised.
 */
// The placing of the registers and the APB interface to the registers were left to the implementer.
// Summary of operation
// - One clock; samples taken on falling edge
// - Parallel layout: I and Q words together
// - Multiplexed: I/Q interleaved, Q bus low
// - Calibration trigger rising edge: 34-cycle sequence
// - Average three samples, subtract from later results
// - Format low binary, high two's complement
// - Format change may corrupt two conversions
// - Standby request alone enters standby state
// - Standby recovery within 800 nanoseconds
// - Deep sleep; recovery under 1 ms
// - Both requests high: deep sleep wins
// - Gain pin selects full-scale span
// - Bit 0 is LSB, bit 9 MSB
// - Parallel data valid after rising edge
// - Mux: flag high I data, low Q
// - Flag rises Q to I, falls I to Q
// - Parallel: flag rises on each new word
// - Parallel latency 2.5 clock cycles
// - Mux I latency 2.5 clock cycles
// - Mux Q latency 3 clock cycles
// - Both channels share one clock domain
`timescale 1ns/1ps
`include "daoc_defs.vh"

module daoc_top #(
  parameter SLEEP_CYCLES = `DAOC_SLEEP_CYCLES,
  parameter STANDBY_CYCLES = `DAOC_STANDBY_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [9:0] i_sample_code,
  input wire [9:0] q_sample_code,
  input wire bus_layout_select,
  input wire offset_cal_trigger,
  input wire code_format_select,
  input wire standby_request,
  input wire deep_sleep_request,
  input wire gain_select,
  output wire [9:0] i_channel_word,
  output reg [9:0] q_channel_word,
  output wire channel_phase_flag,
  output reg core_gain_high,
  output reg core_standby,
  output reg core_deep_sleep,
  output reg cal_busy
);

  // Power state codes, one-hot
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_STANDBY = 4'h2;
  localparam [3:0] ST_SLEEP = 4'h4;
  localparam [3:0] ST_RECOVER = 4'h8;
  // Control register image after reset
  localparam [31:0] CTRL_RESET = `DAOC_CTRL_RESET;

  //////////////////////////////////////////////////////////////////////
  // Helper functions

  // Subtract signed offset from a raw code, clamped to code range
  function [9:0] apply_offset;
    input [9:0] raw;
    input [10:0] offs;
    reg signed [12:0] diff;
    begin
      diff = $signed({3'h0, raw}) - $signed({{2{offs[10]}}, offs});
      if (diff < 0) begin
        apply_offset = 10'h000;
      end else if (diff > $signed({3'h0, `DAOC_CODE_MAX})) begin
        apply_offset = `DAOC_CODE_MAX;
      end else begin
        apply_offset = diff[9:0];
      end
    end
  endfunction

  // Binary to output coding: two's complement flips the MSB
  function [9:0] encode;
    input [9:0] code;
    input twos;
    begin
      encode = {code[9] ^ twos, code[8:0]};
    end
  endfunction

  // Calibration average less midscale, as a signed offset
  function [10:0] cal_offset;
    input [11:0] sum;
    reg [31:0] avg;
    begin
      avg = sum / `DAOC_CAL_SAMPLES;
      cal_offset = avg[10:0] - `DAOC_MIDSCALE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [5:0] pin_meta;
  reg [5:0] pin_sync;

  // Two flops per asynchronous control pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else if (clk_en) begin
      pin_meta <= {gain_select, deep_sleep_request, standby_request,
                   code_format_select, offset_cal_trigger,
                   bus_layout_select};
      pin_sync <= pin_meta;
    end
  end

  wire layout_parallel = pin_sync[0];
  wire cal_pin = pin_sync[1];
  wire twos_sel = pin_sync[2];
  wire standby_req = pin_sync[3];
  wire sleep_req = pin_sync[4];
  wire gain_high = pin_sync[5];

  //////////////////////////////////////////////////////////////////////
  // Power state sequencing

  reg [3:0] pwr_state;
  reg [3:0] next_pwr_state;
  reg [15:0] rec_cnt;
  reg [15:0] next_rec_cnt;
  reg cal_pin_d;

  // Next power state and recovery count
  always @* begin
    next_pwr_state = pwr_state;
    next_rec_cnt = rec_cnt;
    case (pwr_state)
      ST_RUN: begin
        if (sleep_req) begin
          next_pwr_state = ST_SLEEP;
        end else if (standby_req) begin
          next_pwr_state = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (sleep_req) begin
          next_pwr_state = ST_SLEEP;
        end else if (!standby_req) begin
          next_pwr_state = ST_RECOVER;
          next_rec_cnt = STANDBY_CYCLES[15:0] - `DAOC_WAKE_PIPE;
        end
      end
      ST_SLEEP: begin
        if (!sleep_req) begin
          if (standby_req) begin
            next_pwr_state = ST_STANDBY;
          end else begin
            next_pwr_state = ST_RECOVER;
            next_rec_cnt = SLEEP_CYCLES[15:0] - `DAOC_WAKE_PIPE;
          end
        end
      end
      ST_RECOVER: begin
        if (sleep_req) begin
          next_pwr_state = ST_SLEEP;
        end else if (standby_req) begin
          next_pwr_state = ST_STANDBY;
        end else if (rec_cnt == 16'h0000) begin
          next_pwr_state = ST_RUN;
        end else begin
          next_rec_cnt = rec_cnt - 16'h0001;
        end
      end
      default: begin
        next_pwr_state = ST_RUN;
        next_rec_cnt = 16'h0000;
      end
    endcase
  end

  // Power state registers and core control outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state <= ST_RUN;
      rec_cnt <= 16'h0000;
      core_standby <= 1'b0;
      core_deep_sleep <= 1'b0;
      core_gain_high <= 1'b0;
    end else if (clk_en) begin
      pwr_state <= next_pwr_state;
      rec_cnt <= next_rec_cnt;
      core_standby <= next_pwr_state == ST_STANDBY;
      core_deep_sleep <= next_pwr_state == ST_SLEEP;
      core_gain_high <= gain_high;
    end
  end

  wire running = pwr_state == ST_RUN;

  //////////////////////////////////////////////////////////////////////
  // Falling-edge sample capture, both channels on one clock

  reg [9:0] raw_i;
  reg [9:0] raw_q;

  // Sample both converters at the falling edge
  always @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_i <= 10'h000;
      raw_q <= 10'h000;
    end else if (clk_en) begin
      raw_i <= i_sample_code;
      raw_q <= q_sample_code;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Offset calibration sequence

  reg [5:0] cal_cnt;
  reg [11:0] sum_i;
  reg [11:0] sum_q;
  reg [10:0] offs_i;
  reg [10:0] offs_q;
  wire cal_rise = cal_pin & ~cal_pin_d;
  wire take_sample = (cal_cnt >= `DAOC_CAL_FIRST) &&
    (cal_cnt < `DAOC_CAL_FIRST + `DAOC_CAL_SAMPLES);

  // Rising edge start, three samples summed, average less midscale kept as offset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_pin_d <= 1'b0;
      cal_busy <= 1'b0;
      cal_cnt <= 6'h00;
      sum_i <= 12'h000;
      sum_q <= 12'h000;
      offs_i <= 11'h000;
      offs_q <= 11'h000;
    end else if (clk_en) begin
      cal_pin_d <= cal_pin;
      if (!cal_busy) begin
        if (cal_rise && running) begin
          cal_busy <= 1'b1;
          cal_cnt <= 6'h00;
          sum_i <= 12'h000;
          sum_q <= 12'h000;
        end
      end else begin
        if (take_sample) begin
          sum_i <= sum_i + {2'h0, raw_i};
          sum_q <= sum_q + {2'h0, raw_q};
        end
        if (cal_cnt == `DAOC_CAL_CYCLES - 1) begin
          cal_busy <= 1'b0;
          offs_i <= cal_offset(sum_i);
          offs_q <= cal_offset(sum_q);
        end else begin
          cal_cnt <= cal_cnt + 6'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // APB register file

  reg corr_en;
  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pwrite;
  wire addr_ok = (paddr == `DAOC_REG_CTRL) ||
    (paddr == `DAOC_REG_STATUS) || (paddr == `DAOC_REG_OFFSET);
  reg [31:0] rd_mux;

  // Read data selection
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `DAOC_REG_CTRL: begin
        rd_mux[`DAOC_CTRL_CORR_EN_BIT] = corr_en;
      end
      `DAOC_REG_STATUS: begin
        rd_mux[`DAOC_STAT_PARALLEL_BIT] = layout_parallel;
        rd_mux[`DAOC_STAT_TWOS_BIT] = twos_sel;
        rd_mux[`DAOC_STAT_GAIN_BIT] = gain_high;
        rd_mux[`DAOC_STAT_STATE_LSB +: 4] = pwr_state;
        rd_mux[`DAOC_STAT_CAL_BUSY_BIT] = cal_busy;
      end
      `DAOC_REG_OFFSET: begin
        rd_mux[`DAOC_OFFS_I_LSB +: 11] = offs_i;
        rd_mux[`DAOC_OFFS_Q_LSB +: 11] = offs_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Zero-wait slave: answer prepared in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      corr_en <= CTRL_RESET[`DAOC_CTRL_CORR_EN_BIT];
    end else if (clk_en) begin
      pready <= 1'b1;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= ~addr_ok;
      end
      if (apb_write && paddr == `DAOC_REG_CTRL) begin
        corr_en <= pwdata[`DAOC_CTRL_CORR_EN_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Result pipeline: correction, coding, output

  reg [9:0] s1_i;
  reg [9:0] s1_q;
  reg [9:0] s2_i;
  reg [9:0] s2_q;
  reg [9:0] out_i;
  reg [9:0] q_hold;
  reg [9:0] q_late;
  reg pos_tog;
  reg neg_tog;

  // Rising-edge stages: 0.5, 1.5 and 2.5 cycles after the sample
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_i <= 10'h000;
      s1_q <= 10'h000;
      s2_i <= 10'h000;
      s2_q <= 10'h000;
      out_i <= 10'h000;
      q_hold <= 10'h000;
      q_channel_word <= 10'h000;
      pos_tog <= 1'b0;
    end else if (clk_en) begin
      s1_i <= corr_en ? apply_offset(raw_i, offs_i) : raw_i;
      s1_q <= corr_en ? apply_offset(raw_q, offs_q) : raw_q;
      s2_i <= encode(s1_i, twos_sel);
      s2_q <= encode(s1_q, twos_sel);
      if (running) begin
        out_i <= s2_i;
        q_hold <= s2_q;
        pos_tog <= ~pos_tog;
        if (layout_parallel) begin
          q_channel_word <= s2_q;
        end else begin
          q_channel_word <= 10'h000;
        end
      end
    end
  end

  // Falling-edge half: Q word 3 cycles after its sample
  always @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_late <= 10'h000;
      neg_tog <= 1'b0;
    end else if (clk_en) begin
      q_late <= q_hold;
      neg_tog <= pos_tog;
    end
  end

  // Flag high from rising to falling edge after each new word
  assign channel_phase_flag = pos_tog ^ neg_tog;

  // Mux layout: I while flag high, Q while low
  assign i_channel_word = (!layout_parallel && !channel_phase_flag) ?
    q_late : out_i;

endmodule // daoc_top

//--- testbench/daoc_capture.sv
/* Downstream capture model for the converter output buses.
   Assumes words are valid while the phase flag is high. */
`timescale 1ns/1ps
module daoc_capture (
  input wire pclk,
  input wire [9:0] i_word,
  input wire [9:0] q_word,
  input wire flag,
  output logic [9:0] cap_i = 10'h000,
  output logic [9:0] cap_q = 10'h000,
  output logic [9:0] cap_mq = 10'h000,
  output int n_word = 0
);
  // Take a word pair while the strobe stands high
  always @(negedge pclk) begin
    if (flag) begin
      cap_i <= i_word;
      cap_q <= q_word;
      n_word <= n_word + 1;
    end
  end
  // Second half period of a mux cycle carries Q
  always @(posedge pclk) cap_mq <= i_word;
endmodule // daoc_capture

//--- testbench/daoc_top_assertions.sv
/* Port checker for daoc_top.
   Bound to every daoc_top instance; sees its ports only. */
`timescale 1ns/1ps
module daoc_chk #(
  parameter SLEEP_CYCLES = 20
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pslverr,
  input wire bus_layout_select,
  input wire [9:0] q_channel_word,
  input wire channel_phase_flag,
  input wire standby_request,
  input wire deep_sleep_request,
  input wire core_standby,
  input wire core_deep_sleep,
  input wire cal_busy
);
  localparam int SLP_MAX = SLEEP_CYCLES;
  localparam int STANDBY_MAX = 20;
  logic [5:0] busy_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Busy length counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt <= 6'h00;
    else busy_cnt <= cal_busy ? busy_cnt + 6'h01 : 6'h00;
  end
  property p_cal_len;
    $fell(cal_busy) |-> busy_cnt == 6'h22;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal length");
  property p_sleep;
    deep_sleep_request [*6] |-> core_deep_sleep && !core_standby;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_standby;
    (standby_request && !deep_sleep_request) [*6] |-> core_standby;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby");
  property p_standby_rec;
    @(negedge pclk) $fell(standby_request) && !deep_sleep_request
      |-> ##[1:STANDBY_MAX] channel_phase_flag;
  endproperty
  a_standby_rec: assert property (p_standby_rec) else $error("slow wake");
  property p_sleep_rec;
    @(negedge pclk) $fell(deep_sleep_request) && !standby_request
      |-> ##[1:SLP_MAX] channel_phase_flag;
  endproperty
  a_sleep_rec: assert property (p_sleep_rec) else $error("no wake");
  property p_slverr;
    psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08});
  endproperty
  a_slverr: assert property (p_slverr) else $error("bad slverr");
  property p_q_mux;
    @(negedge pclk) ((!bus_layout_select) [*6] ##0 channel_phase_flag)
      |-> q_channel_word == 10'h000;
  endproperty
  a_q_mux: assert property (p_q_mux) else $error("q bus busy");
  property p_strobe;
    @(negedge pclk) $changed(q_channel_word) |-> channel_phase_flag;
  endproperty
  a_strobe: assert property (p_strobe) else $error("no strobe");
  property p_idle;
    @(negedge pclk) core_deep_sleep [*2] |-> !channel_phase_flag;
  endproperty
  a_idle: assert property (p_idle) else $error("flag in sleep");
  c_cal: cover property ($fell(cal_busy));
  c_standby: cover property (core_standby);
  c_sleep: cover property (core_deep_sleep);
endmodule // daoc_chk

bind daoc_top daoc_chk #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_chk (.pclk,
  .presetn, .psel, .penable, .paddr, .pslverr, .bus_layout_select,
  .q_channel_word, .channel_phase_flag, .standby_request,
  .deep_sleep_request, .core_standby, .core_deep_sleep, .cal_busy);

//--- testbench/tb_dual_adc_output_control.sv
/* Self-checking bench for daoc_top over APB and the output buses.
   Assumes the capture model and checker are compiled alongside. */
`timescale 1ns/1ps
`include "daoc_defs.vh"
module tb_dual_adc_output_control;
  logic pclk = 0, presetn = 0, clk_en = 1, err;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, gain_select = 0, offset_cal_trigger = 0;
  logic [9:0] i_sample_code = 10'h2A5, q_sample_code = 10'h0C3;
  logic bus_layout_select = 1, code_format_select = 0;
  logic standby_request = 0, deep_sleep_request = 0;
  wire [9:0] i_channel_word, q_channel_word, cap_i, cap_q, cap_mq;
  wire channel_phase_flag, core_gain_high, core_standby;
  wire core_deep_sleep, cal_busy;
  int n_word, n_mismatch = 0, num_checks = 0, k, c;
  daoc_top #(.SLEEP_CYCLES(20)) dut (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .i_sample_code, .q_sample_code, .bus_layout_select,
    .offset_cal_trigger, .code_format_select, .standby_request,
    .deep_sleep_request, .gain_select, .i_channel_word, .q_channel_word,
    .channel_phase_flag, .core_gain_high, .core_standby, .core_deep_sleep,
    .cal_busy);
  daoc_capture cap (.pclk, .i_word(i_channel_word),
    .q_word(q_channel_word), .flag(channel_phase_flag), .cap_i, .cap_q,
    .cap_mq, .n_word);
  initial forever #20 pclk = ~pclk;
  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task lim(input int n);
    if (n >= 60) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  // One APB transfer; waits for pready at most 60 edges
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 60);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    lim(i);
  endtask
  task wait_word(input int n);
    c = n_word;
    for (k = 0; k < 60 && n_word == c; k++) @(posedge pclk);
    chk(k <= n, 1);
    lim(k);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `DAOC_REG_CTRL, 0);
    chk(rd, `DAOC_CTRL_RESET);
    apb(0, `DAOC_REG_OFFSET, 0);
    chk(rd, 32'h0);
    apb(1, `DAOC_REG_STATUS, 32'hFFFF_FFFF);
    apb(0, `DAOC_REG_STATUS, 0);
    chk(rd, 32'h11);
    apb(0, 8'h0C, 0);
    chk(err, 1);
    chk(rd, 32'h0);
    // Parallel and mux latency, sample to bus
    i_sample_code <= 10'h155;
    repeat (2) @(posedge pclk);
    #1 chk(i_channel_word, 10'h2A5);
    @(posedge pclk);
    #1 chk(i_channel_word, 10'h155);
    @(posedge pclk);
    bus_layout_select <= 0;
    repeat (8) @(posedge pclk);
    i_sample_code <= 10'h2A5;
    q_sample_code <= 10'h0AA;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    #1 chk(i_channel_word, 10'h0C3);
    @(posedge pclk);
    #1 chk(i_channel_word, 10'h2A5);
    @(negedge pclk);
    #1 chk(i_channel_word, 10'h0AA);
    // Every layout and code format
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      bus_layout_select <= m[1];
      code_format_select <= m[0];
      q_sample_code <= 10'h0C3;
      repeat (10) @(posedge pclk);
      #1 chk(cap_i, 10'h2A5 ^ {m[0], 9'h0});
      chk(cap_q, m[1] ? 10'h0C3 ^ {m[0], 9'h0} : 10'h0);
      chk(cap_mq, m[1] ? cap_i : 10'h0C3 ^ {m[0], 9'h0});
    end
    @(posedge pclk);
    code_format_select <= 0;
    gain_select <= 1;
    i_sample_code <= 10'h210;
    q_sample_code <= 10'h1F0;
    repeat (8) @(posedge pclk);
    chk(core_gain_high, 1);
    offset_cal_trigger <= 1;
    for (k = 0; k < 60 && cal_busy !== 1'b1; k++) @(posedge pclk);
    lim(k);
    for (k = 0; k < 60 && cal_busy !== 1'b0; k++) @(posedge pclk);
    lim(k);
    offset_cal_trigger <= 0;
    apb(0, `DAOC_REG_OFFSET, 0);
    chk(rd, 32'h07F0_0010);
    repeat (8) @(posedge pclk);
    chk({cap_i, cap_q}, {10'h200, 10'h200});
    apb(1, `DAOC_REG_CTRL, 0);
    repeat (8) @(posedge pclk);
    chk(cap_i, 10'h210);
    apb(1, `DAOC_REG_CTRL, 1);
    repeat (8) @(posedge pclk);
    chk(cap_i, 10'h200);
    // Power states and recovery
    standby_request <= 1;
    repeat (8) @(posedge pclk);
    chk(core_standby, 1);
    apb(0, `DAOC_REG_STATUS, 0);
    chk(rd, 32'h25);
    deep_sleep_request <= 1;
    repeat (8) @(posedge pclk);
    chk({core_deep_sleep, core_standby}, 2'b10);
    deep_sleep_request <= 0;
    repeat (8) @(posedge pclk);
    standby_request <= 0;
    wait_word(`DAOC_STANDBY_CYCLES + 1);
    deep_sleep_request <= 1;
    repeat (8) @(posedge pclk);
    deep_sleep_request <= 0;
    wait_word(21);
    print_verdict;
  end
endmodule // tb_dual_adc_output_control
